// ===== design/sfb_frontend.sv
/*
 Serial bus front end of a page organised flash: samples select, serial
 clock and serial input, frames operations, assembles bytes MSB first,
 tracks the array location and shifts read data out.
 Assumes the array side consumes rx words, supplies tx bytes on demand
 and raises prog_req during a frame that starts a self-timed operation.
 Serial clock must stay well below a quarter of ref_clk.
*/
`timescale 1ns/1ps
module sfb_frontend #(
	parameter int PROG_CYCLES = sfb_pkg::PROG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so_data,
	output logic so_oe_n,
	input wire logic page_256,
	input wire logic sec_sel,
	input wire logic prog_req,
	output sfb_pkg::sfb_rx_word_t rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output sfb_pkg::sfb_loc_t loc,
	output logic loc_valid,
	output logic busy,
	output logic standby,
	output logic frame_start,
	output logic frame_end,
	output logic rx_overrun
);
	sfb_pkg::sfb_core_t q_ff;
	sfb_pkg::sfb_core_t nxt_q;
	logic sel;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic byte_done;
	logic buf_in_ready;
	logic [7:0] rx_byte;

	// Splits a flat address by page size; security area folds to page 0
	function automatic sfb_pkg::sfb_loc_t sfb_decode(
		input logic [23:0] a,
		input logic p256,
		input logic sec
	);
		sfb_pkg::sfb_loc_t l;
		l = '0;
		if (sec) begin
			l.off = {2'h0, a[6:0]};
		end else if (p256) begin
			l.page = a[19:8];
			l.off = {1'b0, a[7:0]};
		end else begin
			l.page = a[20:9];
			l.off = a[8:0];
		end
		return l;
	endfunction : sfb_decode

	// Last byte index of the current page or of the security area
	function automatic logic [sfb_pkg::OFF_W-1:0] sfb_last_off(
		input logic p256,
		input logic sec
	);
		logic [sfb_pkg::OFF_W-1:0] r;
		r = p256 ? sfb_pkg::LAST_OFF_256 : sfb_pkg::LAST_OFF_264;
		if (sec) begin
			r = sfb_pkg::LAST_OFF_SEC;
		end
		return r;
	endfunction : sfb_last_off

	// Next location; page counter wraps naturally at the array end
	function automatic sfb_pkg::sfb_loc_t sfb_step(
		input sfb_pkg::sfb_loc_t l,
		input logic p256,
		input logic sec
	);
		sfb_pkg::sfb_loc_t r;
		r = l;
		if (l.off >= sfb_last_off(p256, sec)) begin
			r.off = '0;
			if (!sec) begin
				r.page = l.page + 12'h001;
			end
		end else begin
			r.off = l.off + 9'h001;
		end
		return r;
	endfunction : sfb_step

	// Only the second synchroniser stage and its delayed copy are read
	assign sel = ~q_ff.cs_s[1];
	assign cs_fall = q_ff.cs_d & ~q_ff.cs_s[1];
	assign cs_rise = ~q_ff.cs_d & q_ff.cs_s[1];
	// Edges found from samples, so either idle level works
	assign sck_rise = q_ff.sck_s[1] & ~q_ff.sck_d;
	assign sck_fall = ~q_ff.sck_s[1] & q_ff.sck_d;
	assign byte_done = sel & sck_rise & (q_ff.bit_cnt == sfb_pkg::LAST_BIT);
	assign rx_byte = {q_ff.rx_sh[6:0], q_ff.si_s[1]};
	assign tx_ready = sel & sck_fall & (q_ff.st == sfb_pkg::SFB_DATA)
		& (q_ff.bit_cnt == 3'h0);

	always_comb begin
		nxt_q = q_ff;
		nxt_q.cs_s = {q_ff.cs_s[0], cs_n};
		nxt_q.sck_s = {q_ff.sck_s[0], sck};
		nxt_q.si_s = {q_ff.si_s[0], si};
		nxt_q.cs_d = q_ff.cs_s[1];
		nxt_q.sck_d = q_ff.sck_s[1];
		nxt_q.push = 1'b0;
		nxt_q.start = 1'b0;
		nxt_q.stop = 1'b0;
		nxt_q.loc_vld = 1'b0;
		nxt_q.ovr = q_ff.push & ~buf_in_ready;

		// Self-timed program or erase, no host timing involved
		if (q_ff.busy) begin
			if (q_ff.timer == '0) begin
				nxt_q.busy = 1'b0;
			end else begin
				nxt_q.timer = q_ff.timer - 1'b1;
			end
		end

		if (cs_fall) begin
			// Truncated frames leave nothing behind
			nxt_q.st = sfb_pkg::SFB_CMD;
			nxt_q.bit_cnt = '0;
			nxt_q.hdr_cnt = '0;
			nxt_q.raw = '0;
			nxt_q.start = 1'b1;
		end else if (cs_rise) begin
			nxt_q.st = sfb_pkg::SFB_IDLE;
			nxt_q.stop = 1'b1;
			// Array write-back runs as one internal sequence
			if (prog_req && !q_ff.busy && q_ff.st != sfb_pkg::SFB_IDLE) begin
				nxt_q.busy = 1'b1;
				nxt_q.timer = sfb_pkg::TMR_W'(PROG_CYCLES - 1);
			end
		end else if (sel) begin
			// Frames decode even while busy, filling the other buffer
			if (sck_rise && q_ff.st != sfb_pkg::SFB_IDLE) begin
				nxt_q.rx_sh = rx_byte;
				nxt_q.bit_cnt = q_ff.bit_cnt + 3'h1;
			end
			if (byte_done && q_ff.st != sfb_pkg::SFB_IDLE) begin
				nxt_q.push = 1'b1;
				nxt_q.word.data = rx_byte;
				case (q_ff.st)
					sfb_pkg::SFB_CMD: begin
						nxt_q.word.kind = sfb_pkg::SFB_K_OPC;
						nxt_q.st = sfb_pkg::SFB_ADDR;
					end
					sfb_pkg::SFB_ADDR: begin
						nxt_q.word.kind = sfb_pkg::SFB_K_ADR;
						nxt_q.raw = {q_ff.raw[15:0], rx_byte};
						nxt_q.hdr_cnt = q_ff.hdr_cnt + 2'h1;
						if (q_ff.hdr_cnt == sfb_pkg::LAST_HDR) begin
							nxt_q.st = sfb_pkg::SFB_DATA;
							// Page and offset split by page size
							nxt_q.loc = sfb_decode({q_ff.raw[15:0], rx_byte},
								page_256, sec_sel);
							nxt_q.loc_vld = 1'b1;
						end
					end
					sfb_pkg::SFB_DATA: begin
						nxt_q.word.kind = sfb_pkg::SFB_K_DAT;
						// Sequential stream across page boundaries
						nxt_q.loc = sfb_step(q_ff.loc, page_256, sec_sel);
						nxt_q.loc_vld = 1'b1;
					end
					default: begin
						nxt_q.st = sfb_pkg::SFB_IDLE;
					end
				endcase
			end
			// Shift out on falling edges; empty supply reads as all ones
			if (sck_fall && q_ff.st == sfb_pkg::SFB_DATA) begin
				if (q_ff.bit_cnt == 3'h0) begin
					nxt_q.so = tx_valid ? tx_data[7] : sfb_pkg::IDLE_FILL[7];
					nxt_q.tx_sh = {tx_valid ? tx_data[6:0] : sfb_pkg::IDLE_FILL[6:0],
						1'b0};
				end else begin
					nxt_q.so = q_ff.tx_sh[7];
					nxt_q.tx_sh = {q_ff.tx_sh[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q_ff <= sfb_pkg::CORE_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// A stalled consumer backs up here; overflow shows on rx_overrun
	sfb_pair_buf #(
		.W($bits(sfb_pkg::sfb_rx_word_t))
	) u_rx_buf (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(q_ff.push),
		.in_ready(buf_in_ready),
		.in_data(q_ff.word),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	assign so_data = q_ff.so;
	assign so_oe_n = ~sel;
	assign loc = q_ff.loc;
	assign loc_valid = q_ff.loc_vld;
	assign busy = q_ff.busy;
	assign standby = ~sel & ~q_ff.busy;
	assign frame_start = q_ff.start;
	assign frame_end = q_ff.stop;
	assign rx_overrun = q_ff.ovr;

	default clocking sfb_cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	a_deselect_hiz: assert property (q_ff.cs_s[1] |-> so_oe_n && !busy == standby)
		else $error("output driven or standby wrong while deselected");
	a_deselect_ignore: assert property (q_ff.cs_s[1] |=> !q_ff.push && !q_ff.loc_vld)
		else $error("byte accepted while deselected");
	a_frame_begin: assert property (cs_fall |=> q_ff.st == sfb_pkg::SFB_CMD
		&& q_ff.bit_cnt == 3'h0 && frame_start)
		else $error("falling select did not clear the decoder");
	a_frame_end: assert property (cs_rise |=> q_ff.st == sfb_pkg::SFB_IDLE && frame_end)
		else $error("rising select did not end the operation");
	a_busy_active: assert property ($rose(busy) |-> !standby [*8])
		else $error("standby entered during self-timed operation");
	a_busy_timed: assert property ($rose(busy) |-> busy [*8])
		else $error("self-timed operation ended too early");
	a_rise_sample: assert property (byte_done && q_ff.st != sfb_pkg::SFB_IDLE
		|=> q_ff.push && q_ff.word.data == $past(rx_byte))
		else $error("completed byte not pushed on rising edge");
	a_fall_output: assert property ($changed(so_data) |-> $past(sck_fall)
		&& $past(q_ff.st) == sfb_pkg::SFB_DATA)
		else $error("serial output changed outside a falling edge");
	a_opcode_first: assert property (cs_fall ##1 (!cs_rise && !byte_done) [*1]
		##0 1'b1 |-> q_ff.hdr_cnt == 2'h0)
		else $error("header count not cleared at frame start");
	a_page_range: assert property (loc_valid |-> loc.off <= sfb_pkg::LAST_OFF_264)
		else $error("offset beyond page size");

	// Cycle count of the running operation; too long for a repetition
	logic [sfb_pkg::TMR_W-1:0] busy_run_ff;
	always_ff @(posedge ref_clk) begin
		if (reset || !q_ff.busy) begin
			busy_run_ff <= '0;
		end else begin
			busy_run_ff <= busy_run_ff + 1'b1;
		end
	end
	a_busy_length: assert property ($fell(busy)
		|-> busy_run_ff == sfb_pkg::TMR_W'(PROG_CYCLES))
		else $error("self-timed operation length wrong");
	a_busy_standby: assert property (busy |-> !standby)
		else $error("standby shown during self-timed operation");
	a_busy_start: assert property (cs_rise && prog_req && !busy
		&& q_ff.st != sfb_pkg::SFB_IDLE |=> busy)
		else $error("self-timed operation not started at frame end");

	// Byte assembly and output order
	a_rx_msb_first: assert property (sel && sck_rise && !cs_fall
		&& q_ff.st != sfb_pkg::SFB_IDLE
		|=> q_ff.rx_sh == {$past(q_ff.rx_sh[6:0]), $past(q_ff.si_s[1])})
		else $error("input bits not shifted in order");
	a_opcode_kind: assert property (byte_done && !cs_fall
		&& q_ff.st == sfb_pkg::SFB_CMD
		|=> q_ff.word.kind == sfb_pkg::SFB_K_OPC && q_ff.st == sfb_pkg::SFB_ADDR)
		else $error("first byte not taken as opcode");
	a_addr_done: assert property (byte_done && !cs_fall
		&& q_ff.st == sfb_pkg::SFB_ADDR && q_ff.hdr_cnt == sfb_pkg::LAST_HDR
		|=> loc_valid && q_ff.st == sfb_pkg::SFB_DATA)
		else $error("address phase did not end after three bytes");
	a_tx_load: assert property (tx_ready
		|=> so_data == ($past(tx_valid) ? $past(tx_data[7]) : sfb_pkg::IDLE_FILL[7]))
		else $error("first output bit not loaded on falling edge");
	a_tx_shift: assert property (sel && sck_fall && !cs_fall
		&& q_ff.st == sfb_pkg::SFB_DATA && q_ff.bit_cnt != 3'h0
		|=> so_data == $past(q_ff.tx_sh[7]))
		else $error("output bits not shifted in order");
	a_idle_no_take: assert property (!sel |-> !tx_ready && !byte_done)
		else $error("link activity taken while deselected");
	a_overrun_cause: assert property (rx_overrun
		|-> $past(q_ff.push) && !$past(buf_in_ready))
		else $error("overrun flagged without a lost word");

	// Location bookkeeping
	a_size_256: assert property (loc_valid && $past(page_256) && !$past(sec_sel)
		&& $past(q_ff.st) == sfb_pkg::SFB_ADDR |-> loc.off <= sfb_pkg::LAST_OFF_256)
		else $error("offset beyond a 256-byte page");
	a_sec_fold: assert property (loc_valid && $past(sec_sel)
		&& $past(q_ff.st) == sfb_pkg::SFB_ADDR
		|-> loc.page == '0 && loc.off <= sfb_pkg::LAST_OFF_SEC)
		else $error("security location outside its area");
	a_page_cross: assert property (byte_done && !cs_fall
		&& q_ff.st == sfb_pkg::SFB_DATA && !sec_sel
		&& q_ff.loc.off == sfb_last_off(page_256, 1'b0)
		|=> loc.off == '0 && loc.page == $past(q_ff.loc.page) + 12'h001)
		else $error("stream did not move to the next page");

	c_opcode_byte: cover property (q_ff.push && q_ff.word.kind == sfb_pkg::SFB_K_OPC);
	c_read_byte: cover property (tx_ready && tx_valid);
	c_page_cross: cover property (loc_valid && loc.off == '0 && q_ff.st == sfb_pkg::SFB_DATA);
	c_busy_frame: cover property (busy && frame_start);
	c_sec_frame: cover property (loc_valid && sec_sel);

endmodule : sfb_frontend

// ===== design/sfb_pair_buf.sv
/*
 Two-entry buffer with valid/ready on both sides for received words.
 Assumes producer and consumer share ref_clk; in_ready is honest full.
*/
`timescale 1ns/1ps
module sfb_pair_buf #(
	parameter int W = 10
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} sfb_buf_st_t;

	sfb_buf_st_t buf_ff;
	sfb_buf_st_t nxt_buf;
	logic do_in;
	logic do_out;

	assign in_ready = (buf_ff.cnt != 2'h2);
	assign out_valid = (buf_ff.cnt != 2'h0);
	assign out_data = buf_ff.mem[buf_ff.rp];
	assign do_in = in_valid & in_ready;
	assign do_out = out_valid & out_ready;

	always_comb begin
		nxt_buf = buf_ff;
		if (do_in) begin
			nxt_buf.mem[buf_ff.wp] = in_data;
			nxt_buf.wp = ~buf_ff.wp;
		end
		if (do_out) begin
			nxt_buf.rp = ~buf_ff.rp;
		end
		nxt_buf.cnt = buf_ff.cnt + {1'b0, do_in} - {1'b0, do_out};
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			buf_ff <= '0;
		end else begin
			buf_ff <= nxt_buf;
		end
	end

	a_buf_no_overfill: assert property (@(posedge ref_clk) disable iff (reset)
		buf_ff.cnt == 2'h2 && !out_ready |=> buf_ff.cnt == 2'h2)
		else $error("buffer count moved while full and stalled");

endmodule : sfb_pair_buf

// ===== design/sfb_pkg.sv
/*
 Shared constants and types of the serial flash bus front end: sizes of
 the array, pages and security area, timing figures, state codes and
 the packed carriers that cross module boundaries.
 Assumes a single 50 MHz system clock sampling every link pin.
*/
package sfb_pkg;

	localparam int CLK_MHZ = 50;
	// Program or erase time; plain default, shortened in simulation
	localparam int PROG_TIME_US = 1000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int TMR_W = 20;

	localparam int PAGES = 4096;
	localparam int PAGE_W = 12;
	localparam int OFF_W = 9;
	localparam logic [OFF_W-1:0] LAST_OFF_256 = 9'h0FF;
	localparam logic [OFF_W-1:0] LAST_OFF_264 = 9'h107;
	localparam int SEC_BYTES = 128;
	localparam int SEC_USER_BYTES = 64;
	localparam logic [OFF_W-1:0] LAST_OFF_SEC = 9'h07F;

	localparam int ADDR_BYTES = 3;
	localparam logic [1:0] LAST_HDR = 2'h2;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [7:0] IDLE_FILL = 8'hFF;

	typedef enum logic [3:0] {
		SFB_IDLE = 4'h1,
		SFB_CMD = 4'h2,
		SFB_ADDR = 4'h4,
		SFB_DATA = 4'h8
	} sfb_state_t;

	typedef enum logic [1:0] {
		SFB_K_OPC = 2'h0,
		SFB_K_ADR = 2'h1,
		SFB_K_DAT = 2'h2
	} sfb_kind_t;

	typedef struct packed {
		sfb_kind_t kind;
		logic [7:0] data;
	} sfb_rx_word_t;

	typedef struct packed {
		logic [PAGE_W-1:0] page;
		logic [OFF_W-1:0] off;
	} sfb_loc_t;

	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] sck_s;
		logic [1:0] si_s;
		logic cs_d;
		logic sck_d;
		sfb_state_t st;
		logic [2:0] bit_cnt;
		logic [7:0] rx_sh;
		logic [1:0] hdr_cnt;
		logic [23:0] raw;
		logic [7:0] tx_sh;
		logic so;
		sfb_loc_t loc;
		logic loc_vld;
		logic [TMR_W-1:0] timer;
		logic busy;
		logic push;
		sfb_rx_word_t word;
		logic start;
		logic stop;
		logic ovr;
	} sfb_core_t;

	localparam sfb_core_t CORE_RST = '{
		cs_s: 2'h3,
		cs_d: 1'h1,
		st: SFB_IDLE,
		so: 1'h1,
		default: '0
	};

endpackage : sfb_pkg

// ===== sim/sfb_frontend_tb_top.sv
/*
 Self-checking bench of the serial front end, array side played here.
 Assumes the host model drives the link pins at a 160 ns serial period.
*/
`timescale 1ns/1ps
module sfb_frontend_tb_top;
	localparam int PC = 800;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic page_256 = 1'b1;
	logic sec_sel = 1'b0;
	logic prog_req = 1'b0;
	logic rx_ready = 1'b1;
	logic tx_valid = 1'b1;
	logic [7:0] tx_data = 8'h5A;
	logic [7:0] r;
	logic cs_n, sck, si, so_data, so_line, so_oe_n, rx_valid, tx_ready, loc_valid;
	logic busy, standby, frame_start, frame_end, rx_overrun;
	sfb_pkg::sfb_rx_word_t rx_data;
	sfb_pkg::sfb_rx_word_t rxq[$];
	sfb_pkg::sfb_loc_t loc, loc_seen;
	int failures = 0, checks = 0, n_st = 0, n_end = 0, n_ovr = 0, n_loc = 0, n_busy = 0;
	int n_tx = 0;
	// Released output shows the inverse, so a stale sample cannot pass
	assign so_line = so_oe_n ? ~so_data : so_data;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1 && rx_ready) rxq.push_back(rx_data);
		if (frame_start === 1'b1) n_st++;
		if (frame_end === 1'b1) n_end++;
		if (rx_overrun === 1'b1) n_ovr++;
		if (busy === 1'b1) n_busy++;
		if (tx_ready === 1'b1) n_tx++;
		if (loc_valid === 1'b1) begin
			if (n_loc == 0) loc_seen = loc;
			n_loc++;
		end
	end
	sfb_host_model host (.ref_clk(ref_clk), .so_line(so_line), .cs_n(cs_n), .sck(sck), .si(si));
	sfb_frontend #(.PROG_CYCLES(PC)) sfb_frontend_inst (
		.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .so_data(so_data),
		.so_oe_n(so_oe_n), .page_256(page_256), .sec_sel(sec_sel), .prog_req(prog_req),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .loc(loc), .loc_valid(loc_valid),
		.busy(busy), .standby(standby), .frame_start(frame_start), .frame_end(frame_end),
		.rx_overrun(rx_overrun));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic print_verdict;
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic chkq(input logic [9:0] e[$]);
		chk("words", rxq.size(), e.size());
		foreach (e[i]) if (i < rxq.size()) chk("word", rxq[i], e[i]);
		rxq.delete();
	endtask : chkq
	task automatic frame(input logic [7:0] q[$]);
		n_loc = 0;
		n_tx = 0;
		host.sel(1'b0);
		foreach (q[i]) begin
			host.xfer(q[i], 8, r);
			chk("oe_n", so_oe_n, 1'b0);
		end
		host.sel(1'b1);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : frame
	task automatic t_idle;
		chk("oe_n", so_oe_n, 1'b1);
		chk("standby", standby, 1'b1);
		host.xfer(8'hA5, 8, r);
		host.sel(1'b1);
		chk("rx_valid", rx_valid, 1'b0);
		chk("starts", n_st, 0);
	endtask : t_idle
	task automatic t_mode0;
		frame('{8'h0B, 8'h0A, 8'hBC, 8'hDE, 8'h00});
		chk("read", r, 8'h5A);
		chkq('{10'h00B, 10'h10A, 10'h1BC, 10'h1DE, 10'h200});
		chk("loc", loc_seen, {12'hABC, 9'h0DE});
		chk("starts", n_st, 1);
		chk("ends", n_end, 1);
		chk("tx_takes", n_tx, 1);
		chk("oe_n", so_oe_n, 1'b1);
	endtask : t_mode0
	task automatic t_mode3;
		host.cpol = 1'b1;
		page_256 = 1'b0;
		host.sel(1'b0);
		host.xfer(8'hFF, 4, r);
		host.sel(1'b1);
		frame('{8'h3C, 8'h00, 8'h0B, 8'h07, 8'h00});
		chk("read", r, 8'h5A);
		chk("tx_takes", n_tx, 1);
		chkq('{10'h03C, 10'h100, 10'h10B, 10'h107, 10'h200});
		chk("loc", loc_seen, {12'h005, 9'h107});
		chk("loc_next", loc, {12'h006, 9'h000});
	endtask : t_mode3
	task automatic t_busy;
		int i;
		prog_req = 1'b1;
		frame('{8'h82, 8'h00, 8'h00, 8'h00});
		prog_req = 1'b0;
		rxq.delete();
		chk("busy", busy, 1'b1);
		chk("standby", standby, 1'b0);
		frame('{8'h84, 8'h01});
		chkq('{10'h084, 10'h101});
		for (i = 0; i < 1000 && busy !== 1'b0; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("busy_end", busy, 1'b0);
		chk("busy_len", n_busy, PC);
		chk("standby", standby, 1'b1);
	endtask : t_busy
	task automatic t_stall;
		rx_ready = 1'b0;
		sec_sel = 1'b1;
		n_ovr = 0;
		frame('{8'h0B, 8'h01, 8'h02, 8'h03});
		sec_sel = 1'b0;
		chk("lost", n_ovr, 2);
		chk("sec_loc", loc_seen, {12'h000, 9'h003});
		rx_ready = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		chkq('{10'h00B, 10'h101});
	endtask : t_stall
	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		t_idle();
		t_mode0();
		t_mode3();
		t_busy();
		t_stall();
		print_verdict();
	end
	initial begin
		#1500000;
		failures++;
		print_verdict();
	end
endmodule : sfb_frontend_tb_top

// ===== sim/sfb_host_model.sv
/*
 Host master model: drives select, serial clock and serial input pins.
 Assumes the bench ref_clk; half a serial period is 4 ref_clk (80 ns).
*/
`timescale 1ns/1ps
module sfb_host_model (
	input wire logic ref_clk,
	input wire logic so_line,
	output logic cs_n,
	output logic sck,
	output logic si
);
	logic cpol = 1'b0;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task automatic half;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : half
	task automatic sel(input logic lvl);
		half();
		sck = cpol; // Back to idle level
		cs_n = lvl;
		si = ~si; // Released line must not hold a stale bit
		half();
	endtask : sel
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			sck = 1'b0;
			si = tx[i];
			half();
			sck = 1'b1;
			half();
			rx[i] = so_line; // Late in high phase, output long settled
		end
	endtask : xfer
endmodule : sfb_host_model
